// *** cewu_write_unit.sv ***
/*
  Colour expansion write datapath: turns one host byte write into up to
  sixteen memory byte writes with per-byte enables, one cycle later.
  Assumes host writes and configuration come from logic on clk_sys, and
  that memory read data for latch loads arrives on the same clock.
*/
// Function
// RULE1: Write mode bit two selects extended modes
// RULE2: Field 100 is mode four, 101 five
// RULE3: Extension enable on, else normal write behaviour
// RULE4: Map mask widens to eight bits
// RULE5: By-8 shifts host address left three
// RULE6: By-8 ignored when 16-bit enhancement set
// RULE7: By-16 shifts left four, sixteen bytes
// RULE8: High colour bytes from high registers
// RULE9: Mask bit gates both pixel bytes
// RULE10: Wide latch bit makes eight-byte latches
// RULE11: Mode one writes all latched bytes back; code does so only with wide latches, else a plain byte write
// RULE12: Extended modes handle eight pixels per byte
// RULE13: Mode four writes foreground if data, mask
// RULE14: Mode four zero data leaves pixel alone
// RULE15: Mode four 16 bpp writes foreground word
// RULE16: Mode five zero data writes background
// RULE17: Mode five cleared mask suppresses pixel
// RULE18: Background word is high over low
// RULE19: Bit seven maps to lowest pixel
`timescale 1ns/1ps
module cewu_write_unit (
  input  wire logic                         clk_sys,
  input  wire logic                         reset,
  input  wire cewu_pkg::cewu_cfg_type       cfg,
  input  wire logic                         hostWrite,
  input  wire logic [cewu_pkg::HADDR_W-1:0] hostAddr,
  input  wire logic [7:0]                   hostData,
  input  wire logic                         latchLoad,
  input  wire logic [63:0]                  memReadData,
  output logic                              memWrite,
  output cewu_pkg::cewu_mem_type            memOut,
  output logic                              extActive,
  output logic                              wideLatch
);
  import cewu_pkg::*;

  logic              extEn;
  logic              by16;
  logic              by8;
  logic              isMode4;
  logic              isMode5;
  logic              latchWb;
  logic [7:0]        mask8;
  logic [63:0]       latch_r;
  logic              memWrite_r;
  cewu_mem_type      mem_r;
  cewu_mem_type      mem_nxt;

  // Mode decode from the two configuration registers
  assign extEn   = cfg.modeExtensions[MX_EXTWR];              // RULE3
  assign by16    = extEn & cfg.modeExtensions[MX_BY16];       // RULE7
  assign by8     = cfg.modeExtensions[MX_BY8]
                 & ~cfg.modeExtensions[MX_BY16];              // RULE6
  assign isMode4 = extEn & cfg.graphicsWriteMode[WM_EXT_BIT]
                 & (cfg.graphicsWriteMode[2:0] == WM_EXT4);   // RULE1 RULE2
  assign isMode5 = extEn & cfg.graphicsWriteMode[WM_EXT_BIT]
                 & (cfg.graphicsWriteMode[2:0] == WM_EXT5);   // RULE1 RULE2
  assign wideLatch = cfg.modeExtensions[MX_WIDELT];           // RULE10
  assign latchWb   = wideLatch
                   & (cfg.graphicsWriteMode[2:0] == WM_NORMAL1);
  assign extActive = isMode4 | isMode5;

  // Eight-bit mask only in extended modes; normal VGA keeps four planes
  assign mask8 = extActive ? cfg.pixelMapMask
                           : {4'h0, cfg.pixelMapMask[3:0]};   // RULE4

  // Read latches; upper half only loads when widened
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      latch_r <= 64'h0;
    end else if (latchLoad) begin
      latch_r[31:0] <= memReadData[31:0];
      if (wideLatch) begin
        latch_r[63:32] <= memReadData[63:32];                 // RULE10
      end
    end
  end

  // Build the block write for the current host byte
  always_comb begin
    logic       pixOn;
    logic       dBit;
    logic [7:0] lo;
    logic [7:0] hi;
    mem_nxt = '0;
    pixOn   = 1'b0;
    dBit    = 1'b0;
    lo      = RST_BYTE;
    hi      = RST_BYTE;
    if (extActive) begin
      // Address shift picks an eight-pixel block
      if (by16) begin
        mem_nxt.addr = MADDR_W'({hostAddr, 4'h0});            // RULE7
      end else if (by8) begin
        mem_nxt.addr = MADDR_W'({hostAddr, 3'h0});            // RULE5
      end else begin
        mem_nxt.addr = MADDR_W'(hostAddr);
      end
      for (int p = 0; p < PIX_BLOCK; p++) begin              // RULE12
        dBit  = hostData[PIX_BLOCK-1-p];                      // RULE19
        pixOn = mask8[PIX_BLOCK-1-p]
              & (dBit | isMode5);                             // RULE14 RULE17
        lo = dBit ? cfg.foregroundLowByte                     // RULE13
                  : cfg.backgroundLowByte;                    // RULE16
        hi = dBit ? cfg.foregroundHighByte                    // RULE8 RULE15
                  : cfg.backgroundHighByte;                   // RULE18
        if (by16) begin
          mem_nxt.data[p*16 +: 16] = {hi, lo};
          mem_nxt.byteEn[p*2 +: 2] = {2{pixOn}};              // RULE9
        end else begin
          mem_nxt.data[p*8 +: 8] = lo;
          mem_nxt.byteEn[p]      = pixOn;
        end
      end
    end else if (latchWb) begin
      // Whole eight-byte latch written back in one host cycle
      mem_nxt.addr        = MADDR_W'({hostAddr, 3'h0});
      mem_nxt.data[63:0]  = latch_r;                          // RULE11
      mem_nxt.byteEn[7:0] = 8'hff;
    end else begin
      // Plain byte write; mask limited to four planes
      mem_nxt.addr       = MADDR_W'(hostAddr);
      mem_nxt.data[7:0]  = hostData;
      mem_nxt.byteEn[3:0] = mask8[3:0];                       // RULE3
    end
  end

  // Registered memory request, one cycle after the host write
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      memWrite_r <= 1'b0;
      mem_r      <= '0;
    end else begin
      memWrite_r <= hostWrite;
      if (hostWrite) begin
        mem_r <= mem_nxt;
      end
    end
  end

  assign memWrite = memWrite_r;
  assign memOut   = mem_r;

  // Checks; sequences name the write flavours the properties share
  sequence s_hostM4Zero;
    hostWrite && isMode4 && !by16 && !hostData[7];
  endsequence

  sequence s_ext8Write;
    hostWrite && extActive && !by16;
  endsequence

  sequence s_ext16Write;
    hostWrite && extActive && by16;
  endsequence

  sequence s_mode5Write8;
    hostWrite && isMode5 && !by16;
  endsequence

  sequence s_mode4Write16;
    hostWrite && isMode4 && by16;
  endsequence

  sequence s_plainWrite;
    hostWrite && !extActive && !latchWb;
  endsequence

  // Zero data bit in mode 4 must leave its pixel alone
  AST_MODE4_ZERO_KEEP: assert property ( // RULE14
    @(posedge clk_sys) disable iff (reset)
    s_hostM4Zero |=> memWrite && !memOut.byteEn[0])
    else $error("mode 4 zero bit wrote pixel");

  // Mode 5 paints the background where data is zero
  AST_MODE5_BG: assert property ( // RULE16
    @(posedge clk_sys) disable iff (reset)
    s_mode5Write8 ##0 (!hostData[7] && mask8[7]) |=>
    memOut.byteEn[0] && memOut.data[7:0] == $past(cfg.backgroundLowByte))
    else $error("mode 5 background missing");

  // Cleared mask bit blocks both bytes of a wide pixel
  AST_MODE5_MASK: assert property ( // RULE17
    @(posedge clk_sys) disable iff (reset)
    hostWrite && isMode5 && by16 && !mask8[0] |=>
    memOut.byteEn[15:14] == 2'h0)
    else $error("masked 16 bpp pixel written");

  AST_BY16_SHIFT: assert property ( // RULE7
    @(posedge clk_sys) disable iff (reset)
    s_ext16Write |=> memOut.addr[3:0] == 4'h0
    && memOut.addr[HADDR_W+3:4] == $past(hostAddr))
    else $error("by-16 shift wrong");

  AST_BY8_SHIFT: assert property ( // RULE5
    @(posedge clk_sys) disable iff (reset)
    hostWrite && extActive && by8 |=> memOut.addr[2:0] == 3'h0
    && memOut.addr[HADDR_W+2:3] == $past(hostAddr))
    else $error("by-8 shift wrong");

  AST_M4_FG16: assert property ( // RULE15
    @(posedge clk_sys) disable iff (reset)
    s_mode4Write16 ##0 (hostData[0] && mask8[0]) |=>
    memOut.byteEn[15:14] == 2'h3 && memOut.data[127:112] ==
    {$past(cfg.foregroundHighByte), $past(cfg.foregroundLowByte)})
    else $error("mode 4 16 bpp foreground wrong");

  AST_M4_FG8: assert property ( // RULE13
    @(posedge clk_sys) disable iff (reset)
    hostWrite && isMode4 && !by16 && hostData[7] && mask8[7] |=>
    memOut.byteEn[0] && memOut.data[7:0] == $past(cfg.foregroundLowByte))
    else $error("mode 4 foreground wrong");

  // Latch contents as they stood when the host byte was taken
  AST_LATCH_WB: assert property ( // RULE11
    @(posedge clk_sys) disable iff (reset)
    hostWrite && !extActive && latchWb |=>
    memOut.byteEn[7:0] == 8'hff && memOut.data[63:0] == $past(latch_r))
    else $error("latch write-back incomplete");

  AST_BG_WORD: assert property ( // RULE18
    @(posedge clk_sys) disable iff (reset)
    hostWrite && isMode5 && by16 && !hostData[7] |=>
    memOut.data[15:0] ==
    {$past(cfg.backgroundHighByte), $past(cfg.backgroundLowByte)})
    else $error("background word wrong");

  AST_NORMAL_MASK: assert property ( // RULE4
    @(posedge clk_sys) disable iff (reset)
    s_plainWrite |=> memOut.byteEn[15:4] == 12'h0)
    else $error("normal write used wide mask");

  // Every taken host byte gives exactly one memory request
  AST_WRITE_ANSWER: assert property ( // RULE12
    @(posedge clk_sys) disable iff (reset)
    hostWrite |=> memWrite)
    else $error("host write not answered");

  AST_WRITE_PULSE: assert property ( // RULE12
    @(posedge clk_sys) disable iff (reset)
    !hostWrite |=> !memWrite)
    else $error("memory write without host write");

  // Request stays put between writes so memory sees a stable word
  AST_REQ_HOLD: assert property ( // RULE12
    @(posedge clk_sys) disable iff (reset)
    !hostWrite |=> $stable(memOut))
    else $error("memory request moved while idle");

  // Mode field bit two is part of the extended decode
  AST_MODE_BIT2: assert property ( // RULE1
    @(posedge clk_sys) disable iff (reset)
    !cfg.graphicsWriteMode[WM_EXT_BIT] |-> !extActive)
    else $error("extended mode without field bit two");

  AST_MODE_FIELD: assert property ( // RULE2
    @(posedge clk_sys) disable iff (reset)
    extActive |-> cfg.graphicsWriteMode[2:0] == WM_EXT4
    || cfg.graphicsWriteMode[2:0] == WM_EXT5)
    else $error("extended mode from wrong field code");

  // Extension enable off rules out modes 4 and 5; wide-latch write-back in mode 1 still runs
  AST_EXT_ENABLE: assert property ( // RULE3
    @(posedge clk_sys) disable iff (reset)
    !cfg.modeExtensions[MX_EXTWR] |-> !extActive)
    else $error("extended mode while disabled");

  AST_NORMAL_DATA: assert property ( // RULE3
    @(posedge clk_sys) disable iff (reset)
    s_plainWrite |=> memOut.data[7:0] == $past(hostData)
    && memOut.addr == MADDR_W'($past(hostAddr)))
    else $error("plain byte write wrong");

  // High mask bit only reaches a lane once the mask is widened
  AST_EXT_MASK8: assert property ( // RULE4
    @(posedge clk_sys) disable iff (reset)
    s_ext8Write ##0 (cfg.pixelMapMask[7] && (hostData[7] || isMode5))
    |=> memOut.byteEn[0])
    else $error("wide mask bit ignored");

  // Extended mode without by-8 or by-16 keeps packed addressing
  AST_UNSHIFTED: assert property ( // RULE5
    @(posedge clk_sys) disable iff (reset)
    hostWrite && extActive && !by16 && !by8 |=>
    memOut.addr == MADDR_W'($past(hostAddr)))
    else $error("address shifted without by-8");

  // With both select bits set the 16-bit shift must win
  AST_BY8_IGNORED: assert property ( // RULE6
    @(posedge clk_sys) disable iff (reset)
    hostWrite && extActive && cfg.modeExtensions[MX_BY16]
    && cfg.modeExtensions[MX_BY8] |=>
    memOut.addr[HADDR_W+3:4] == $past(hostAddr))
    else $error("by-8 not ignored");

  AST_HI_FG: assert property ( // RULE8
    @(posedge clk_sys) disable iff (reset)
    s_mode4Write16 ##0 hostData[7] |=>
    memOut.data[15:8] == $past(cfg.foregroundHighByte))
    else $error("foreground high byte wrong");

  // Both bytes of a wide pixel share one enable
  AST_PAIR_FIRST: assert property ( // RULE9
    @(posedge clk_sys) disable iff (reset)
    s_ext16Write |=> memOut.byteEn[0] == memOut.byteEn[1])
    else $error("first wide pixel split");

  AST_PAIR_LAST: assert property ( // RULE9
    @(posedge clk_sys) disable iff (reset)
    s_ext16Write |=> memOut.byteEn[14] == memOut.byteEn[15])
    else $error("last wide pixel split");

  AST_WIDE_LOAD: assert property ( // RULE10
    @(posedge clk_sys) disable iff (reset)
    latchLoad && wideLatch |=> latch_r == $past(memReadData))
    else $error("wide latch load wrong");

  // Narrow latches must not disturb the upper four bytes
  AST_NARROW_LOAD: assert property ( // RULE10
    @(posedge clk_sys) disable iff (reset)
    latchLoad && !wideLatch |=>
    latch_r[63:32] == $past(latch_r[63:32])
    && latch_r[31:0] == $past(memReadData[31:0]))
    else $error("narrow latch load wrong");

  AST_LATCH_ADDR: assert property ( // RULE11
    @(posedge clk_sys) disable iff (reset)
    hostWrite && !extActive && latchWb |=> memOut.addr[2:0] == 3'h0
    && memOut.addr[HADDR_W+2:3] == $past(hostAddr))
    else $error("latch write-back address wrong");

  // Eight-bit pixels never reach the upper lanes
  AST_EXT8_LANES: assert property ( // RULE12
    @(posedge clk_sys) disable iff (reset)
    s_ext8Write |=> memOut.byteEn[15:8] == 8'h00)
    else $error("8 bpp block spilled into upper lanes");

  AST_M4_ALL_ON: assert property ( // RULE13
    @(posedge clk_sys) disable iff (reset)
    hostWrite && isMode4 && !by16 && hostData == 8'hff
    && mask8 == 8'hff |=> memOut.byteEn == 16'h00ff)
    else $error("full mode 4 block incomplete");

  AST_M4_ZERO16: assert property ( // RULE14
    @(posedge clk_sys) disable iff (reset)
    s_mode4Write16 ##0 !hostData[0] |=> memOut.byteEn[15:14] == 2'h0)
    else $error("mode 4 zero bit wrote wide pixel");

  AST_M5_FG: assert property ( // RULE16
    @(posedge clk_sys) disable iff (reset)
    s_mode5Write8 ##0 (hostData[0] && mask8[0]) |=>
    memOut.byteEn[7] && memOut.data[63:56] == $past(cfg.foregroundLowByte))
    else $error("mode 5 foreground wrong");

  // Mask beats data in mode 5 as well
  AST_M5_MASK8: assert property ( // RULE17
    @(posedge clk_sys) disable iff (reset)
    s_mode5Write8 ##0 !mask8[7] |=> !memOut.byteEn[0])
    else $error("masked 8 bpp pixel written");

  AST_BG_WORD_LAST: assert property ( // RULE18
    @(posedge clk_sys) disable iff (reset)
    hostWrite && isMode5 && by16 && !hostData[0] |=>
    memOut.data[127:112] ==
    {$past(cfg.backgroundHighByte), $past(cfg.backgroundLowByte)})
    else $error("last background word wrong");

  // Data bit seven lands on the lowest address
  AST_BIT7_FIRST: assert property ( // RULE19
    @(posedge clk_sys) disable iff (reset)
    hostWrite && isMode4 && !by16 && hostData == 8'h80 && mask8[7]
    |=> memOut.byteEn[7:0] == 8'h01)
    else $error("pixel order reversed");

endmodule

// *** cewu_pkg.sv ***
/*
  Package for the colour expansion write unit: field positions, mode codes,
  widths and the packed structs that carry configuration and memory writes.
  Assumes a single clock domain and no register bus; bits arrive as ports.
*/
package cewu_pkg;

  // Write mode field encodings
  localparam logic [2:0] WM_NORMAL1 = 3'h1;
  localparam logic [2:0] WM_EXT4    = 3'h4;
  localparam logic [2:0] WM_EXT5    = 3'h5;
  localparam int         WM_EXT_BIT = 2;

  // Mode extension bit positions
  localparam int MX_BY8    = 1;
  localparam int MX_EXTWR  = 2;
  localparam int MX_WIDELT = 3;
  localparam int MX_BY16   = 4;

  // Address shifts and block geometry
  localparam int SHIFT_BY8  = 3;
  localparam int SHIFT_BY16 = 4;
  localparam int PIX_BLOCK  = 8;
  localparam int LANES      = 16;
  localparam int HADDR_W    = 20;
  localparam int MADDR_W    = 24;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef struct packed {
    logic [7:0] graphicsWriteMode;
    logic [7:0] modeExtensions;
    logic [7:0] pixelMapMask;
    logic [7:0] backgroundLowByte;
    logic [7:0] foregroundLowByte;
    logic [7:0] backgroundHighByte;
    logic [7:0] foregroundHighByte;
  } cewu_cfg_type;

  typedef struct packed {
    logic [MADDR_W-1:0]  addr;
    logic [LANES*8-1:0]  data;
    logic [LANES-1:0]    byteEn;
  } cewu_mem_type;

endpackage

// *** cewu_host_model.sv ***
/*
  Host CPU model: issues byte writes as one-cycle pulses.
  Assumes the bench calls putByte from its main sequence.
*/
`timescale 1ns/1ps
module cewu_host_model (
  input  wire logic                         clk_sys,
  output logic                              hostWrite,
  output logic [cewu_pkg::HADDR_W-1:0]      hostAddr,
  output logic [7:0]                        hostData
);
  initial begin
    hostWrite = 1'b0;
    hostAddr = '0;
    hostData = 8'h00;
  end

  // One byte cycle, launched just after an edge
  task automatic putByte(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    hostWrite = 1'b1;
    hostAddr = a;
    hostData = d;
    @(posedge clk_sys);
    #1;
    hostWrite = 1'b0;
    // Stale bus shows the inverse, so old values cannot match
    hostAddr = ~a;
    hostData = ~d;
  endtask
endmodule

// *** color_expansion_write_unit_tb.sv ***
/*
  Self-checking bench for the colour expansion write unit.
  Assumes a one-cycle write latency and fixed colour bytes.
*/
`timescale 1ns/1ps
module color_expansion_write_unit_tb;
  import cewu_pkg::*;
  logic clk_sys, reset, latchLoad, memWrite, extActive, wideLatch, hostWrite;
  logic [HADDR_W-1:0] hostAddr;
  logic [7:0]         hostData;
  logic [63:0]        memReadData;
  cewu_cfg_type       cfg;
  cewu_mem_type       memOut, e;
  int                 num_errors, total_checks, cycles;

  cewu_write_unit dut (.clk_sys(clk_sys), .reset(reset), .cfg(cfg),
    .hostWrite(hostWrite), .hostAddr(hostAddr), .hostData(hostData),
    .latchLoad(latchLoad), .memReadData(memReadData),
    .memWrite(memWrite), .memOut(memOut), .extActive(extActive),
    .wideLatch(wideLatch));
  cewu_host_model host (.clk_sys(clk_sys), .hostWrite(hostWrite),
    .hostAddr(hostAddr), .hostData(hostData));

  always #2 clk_sys = ~clk_sys;

  // Hang guard well above the twenty-odd cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      results();
    end
  end

  task automatic cmp(input logic [127:0] s, input logic [127:0] x);
    total_checks++;
    if (s !== x) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  // Data compared only on enabled lanes; others are don't care
  task automatic chk();
    logic [127:0] m;
    for (int i = 0; i < 16; i++) m[8*i +: 8] = {8{e.byteEn[i]}};
    cmp(memWrite, 1'b1);
    cmp(memOut.addr, e.addr);
    cmp(memOut.byteEn, e.byteEn);
    cmp(memOut.data & m, e.data & m);
    @(posedge clk_sys);
    #1;
    cmp(memWrite, 1'b0);
  endtask

  // Expected block from data bit 7-p and mask bit 7-p for pixel p
  task automatic run(input logic [7:0] wm, mx, mk, d, input logic m5, w);
    logic b;
    cfg.graphicsWriteMode = wm;
    cfg.modeExtensions = mx;
    cfg.pixelMapMask = mk;
    e = '0;
    e.addr = 24'(20'h00123) << (w ? 4 : 3);
    for (int p = 0; p < 8; p++) begin
      b = d[7-p];
      if (mk[7-p] && (m5 || b)) begin
        e.byteEn[p << w +: 2] = w ? 2'h3 : 2'h1;
        e.data[16*p +: 16] = b ? {8'h3c, 8'h5a} : {8'hc3, 8'ha5};
        if (!w) e.data[8*p +: 8] = b ? 8'h5a : 8'ha5;
      end
    end
    host.putByte(20'h00123, d);
    cmp(extActive, 1'b1);
    chk();
  endtask

  task automatic s_m4b8();
    run(8'h04, 8'h06, 8'hf0, 8'hc3, 1'b0, 1'b0);
  endtask
  task automatic s_m5b8();
    run(8'h05, 8'h06, 8'h7e, 8'h5a, 1'b1, 1'b0);
  endtask
  task automatic s_m4b16();
    run(8'h04, 8'h16, 8'hff, 8'h81, 1'b0, 1'b1);
  endtask
  task automatic s_m5b16();
    run(8'h05, 8'h14, 8'h3c, 8'h0f, 1'b1, 1'b1);
  endtask

  task automatic s_normal();
    cfg.modeExtensions = 8'h00;
    cfg.pixelMapMask = 8'hf5;
    e = '0;
    e.addr = 24'h000045;
    e.data[7:0] = 8'h9e;
    e.byteEn = 16'h0005;
    host.putByte(20'h00045, 8'h9e);
    cmp(extActive, 1'b0);
    chk();
    cfg.graphicsWriteMode = 8'h00;
    cfg.modeExtensions = 8'h04;
    #1;
    cmp(extActive, 1'b0);
  endtask

  task automatic s_latch();
    cfg.modeExtensions = 8'h08;
    cfg.graphicsWriteMode = 8'h01;
    memReadData = 64'h0123456789abcdef;
    @(posedge clk_sys);
    #1;
    latchLoad = 1'b1;
    @(posedge clk_sys);
    #1;
    latchLoad = 1'b0;
    memReadData = ~memReadData;
    cmp(wideLatch, 1'b1);
    e = '0;
    e.addr = 24'h000100;
    e.data[63:0] = 64'h0123456789abcdef;
    e.byteEn = 16'h00ff;
    host.putByte(20'h00020, 8'h00);
    chk();
  endtask

  task automatic results();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    latchLoad = 1'b0;
    memReadData = 64'h0;
    cfg = '0;
    cfg.foregroundLowByte = 8'h5a;
    cfg.backgroundLowByte = 8'ha5;
    cfg.foregroundHighByte = 8'h3c;
    cfg.backgroundHighByte = 8'hc3;
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    cmp(memWrite, 1'b0);
    s_m4b8();
    s_m5b8();
    s_m4b16();
    s_m5b16();
    s_normal();
    s_latch();
    results();
  end
endmodule
